/* core/css_top.sv */
// charge-state sequencer with apb register slave and interrupt
// assumes comparator results, timer oscillator and the request pin are asynchronous
// Summary of operation
// - rising edge on charge request starts a charge cycle
// - below trickle threshold stay in trickle, code 00
// - trickle threshold met moves to bulk; skip trickle if already above
// - bulk state drives code 01
// - feedback at 95% of reference moves bulk to overcharge
// - overcharge entry drives code 10
// - overcharge timer starts at overcharge entry and runs to expiry
// - timer is 14-bit, clocked by timer oscillator, expires after full range
// - current above near-full threshold drives code 11
// - near-full does not stop charging; only expiry or removal ends it
// - on expiry actively pull charge request low and end cycle
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "css_consts.svh"

module css_top #(
    parameter int ADDR_W       = 8,
    parameter int TIMER_W      = `CSS_TIMER_W,
    parameter int PULL_CYCLES  = `CSS_PULL_CYCLES
) (
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic                     irq,
    input  wire logic                chargeRequestIn,
    output logic                     chargeRequestOut,
    output logic                     chargeRequestOe,
    input  wire css_pkg::css_sense_t senseIn,
    input  wire logic                timerOscIn,
    output logic                     stateCodeLow,
    output logic                     stateCodeHigh
);
    import css_pkg::*;

    // two-stage synchronisers; third stage only feeds edge detection
    css_sense_t senseMeta_reg;
    css_sense_t senseSync_reg;
    logic [2:0] pinSync_reg;
    logic [2:0] oscSync_reg;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            senseMeta_reg <= '0;
            senseSync_reg <= '0;
            pinSync_reg   <= 3'h0;
            oscSync_reg   <= 3'h0;
        end else begin
            senseMeta_reg <= senseIn;
            senseSync_reg <= senseMeta_reg;
            pinSync_reg   <= {pinSync_reg[1:0], chargeRequestIn};
            oscSync_reg   <= {oscSync_reg[1:0], timerOscIn};
        end
    end

    wire pinLevel = pinSync_reg[1];
    wire pinRise  = pinSync_reg[1] & ~pinSync_reg[2];
    wire oscTick  = oscSync_reg[1] & ~oscSync_reg[2];
    wire lockout  = senseSync_reg.supplyLockout;

    // register file
    logic                 ctrlEn_reg;
    logic                 swStart_reg;
    logic [`CSS_IRQ_W-1:0] irqStat_reg;
    logic [`CSS_IRQ_W-1:0] irqStat_next;
    logic [`CSS_IRQ_W-1:0] irqMask_reg;
    logic [31:0]          prdata_reg;
    logic                 pslverr_reg;

    css_state_t             state_reg;
    css_state_t             state_next;
    logic [1:0]             stateCode_reg;
    logic [1:0]             stateCode_next;
    logic [`CSS_HOLD_W-1:0] hold_reg;
    logic [`CSS_HOLD_W-1:0] hold_next;
    logic                   pullOe_reg;
    logic [TIMER_W-1:0]     timerCount;
    logic                   timerExpired;

    wire setupPhase = psel & ~penable;
    wire accessDone = psel & penable;
    wire hitCtrl    = paddr == ADDR_W'(`CSS_OFF_CTRL);
    wire hitStatus  = paddr == ADDR_W'(`CSS_OFF_STATUS);
    wire hitIrqStat = paddr == ADDR_W'(`CSS_OFF_IRQ_STAT);
    wire hitIrqMask = paddr == ADDR_W'(`CSS_OFF_IRQ_MASK);
    wire mapped     = hitCtrl | hitStatus | hitIrqStat | hitIrqMask;
    wire wrCommit   = accessDone & pwrite;
    wire wrCtrl     = wrCommit & hitCtrl;
    wire wrIrqStat  = wrCommit & hitIrqStat;
    wire wrIrqMask  = wrCommit & hitIrqMask;
    wire busy       = state_reg != CSS_IDLE;

    logic [31:0] statusWord;
    always_comb begin
        statusWord = 32'h0;
        statusWord[`CSS_ST_CODE_LSB +: 2]        = stateCode_reg;
        statusWord[`CSS_ST_PIN_BIT]              = pinLevel;
        statusWord[`CSS_ST_BUSY_BIT]             = busy;
        statusWord[`CSS_ST_TIMER_LSB +: TIMER_W] = timerCount;
    end

    wire [31:0] readMux =
        hitCtrl    ? {30'h0, 1'b0, ctrlEn_reg} :
        hitStatus  ? statusWord :
        hitIrqStat ? {{(32-`CSS_IRQ_W){1'b0}}, irqStat_reg} :
        hitIrqMask ? {{(32-`CSS_IRQ_W){1'b0}}, irqMask_reg} : 32'h0;

    // read data and error are captured in setup, so access never waits
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
            ctrlEn_reg  <= `CSS_CTRL_RESET;
            swStart_reg <= 1'b0;
            irqMask_reg <= `CSS_IRQ_MASK_RESET;
            irqStat_reg <= '0;
        end else begin
            if (setupPhase) begin
                prdata_reg  <= pwrite ? 32'h0 : readMux;
                pslverr_reg <= ~mapped;
            end
            if (wrCtrl)
                ctrlEn_reg <= pwdata[`CSS_CTRL_EN_BIT];
            swStart_reg <= wrCtrl & pwdata[`CSS_CTRL_START_BIT];
            if (wrIrqMask)
                irqMask_reg <= pwdata[`CSS_IRQ_W-1:0];
            irqStat_reg <= irqStat_next;
        end
    end

    assign pready  = accessDone;
    assign pslverr = accessDone & pslverr_reg;
    assign prdata  = prdata_reg;
    assign irq     = |(irqStat_reg & irqMask_reg);

    // start request; ignored while the pin is pulled or settling
    wire startReq      = (pinRise | swStart_reg) & ctrlEn_reg;
    wire pinOwned      = (state_reg == CSS_PULL) | (state_reg == CSS_SETTLE);
    wire startAccepted = startReq & ~lockout & ~pinOwned;
    wire bulkOrTrickle = senseSync_reg.trickleAbove;
    wire timerClear    = startAccepted | lockout;
    wire holdDone      = hold_reg == '0;

    always_comb begin
        state_next = state_reg;
        hold_next  = holdDone ? hold_reg : hold_reg - 1'b1;
        if (lockout) begin
            state_next = CSS_IDLE;
            hold_next  = '0;
        end else if (startAccepted) begin
            state_next = bulkOrTrickle ? CSS_BULK : CSS_TRICKLE;
        end else begin
            unique case (state_reg)
                CSS_IDLE:    state_next = CSS_IDLE;
                CSS_TRICKLE: if (senseSync_reg.trickleAbove)
                                 state_next = CSS_BULK;
                CSS_BULK:    if (senseSync_reg.feedbackAt95)
                                 state_next = CSS_OVER;
                CSS_OVER: begin
                    // near-full only changes the code, never the state
                    if (timerExpired) begin
                        state_next = CSS_PULL;
                        hold_next  = `CSS_HOLD_W'(PULL_CYCLES - 1);
                    end
                end
                CSS_PULL: begin
                    if (holdDone) begin
                        state_next = CSS_SETTLE;
                        hold_next  = `CSS_HOLD_W'(`CSS_SETTLE_CYCLES - 1);
                    end
                end
                // lets the released pin clear the synchroniser before edges count
                CSS_SETTLE:  if (holdDone)
                                 state_next = CSS_IDLE;
                default:     state_next = CSS_IDLE;
            endcase
        end
    end

    always_comb begin
        unique case (state_next)
            CSS_TRICKLE: stateCode_next = `CSS_CODE_TRICKLE;
            CSS_BULK:    stateCode_next = `CSS_CODE_BULK;
            CSS_OVER:    stateCode_next = senseSync_reg.nearFullAbove ?
                                          `CSS_CODE_NEAR : `CSS_CODE_OVER;
            default:     stateCode_next = `CSS_CODE_TRICKLE;
        endcase
    end

    wire [`CSS_IRQ_W-1:0] irqEvents;
    assign irqEvents[`CSS_IRQ_START] = startAccepted;
    assign irqEvents[`CSS_IRQ_BULK]  = (state_next == CSS_BULK) & (state_reg != CSS_BULK);
    assign irqEvents[`CSS_IRQ_OVER]  = (state_next == CSS_OVER) & (state_reg != CSS_OVER);
    assign irqEvents[`CSS_IRQ_NEAR]  = (stateCode_next == `CSS_CODE_NEAR) &
                                       (stateCode_reg != `CSS_CODE_NEAR);
    assign irqEvents[`CSS_IRQ_DONE]  = timerExpired & (state_reg == CSS_OVER);
    // a new event wins over a same-cycle clear
    assign irqStat_next = (irqStat_reg & ~(wrIrqStat ? pwdata[`CSS_IRQ_W-1:0] : '0)) | irqEvents;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg     <= CSS_IDLE;
            stateCode_reg <= `CSS_CODE_TRICKLE;
            hold_reg      <= '0;
            pullOe_reg    <= 1'b0;
        end else begin
            state_reg     <= state_next;
            stateCode_reg <= stateCode_next;
            hold_reg      <= hold_next;
            pullOe_reg    <= state_next == CSS_PULL;
        end
    end

    css_timer #(
        .WIDTH   (TIMER_W)
    ) overTimer (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clear   (timerClear),
        .run     (state_reg == CSS_OVER),
        .tick    (oscTick),
        .count   (timerCount),
        .expired (timerExpired)
    );

    // open drain: only ever drives low
    assign chargeRequestOut = 1'b0;
    assign chargeRequestOe  = pullOe_reg;
    assign stateCodeLow     = stateCode_reg[0];
    assign stateCodeHigh    = stateCode_reg[1];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    property p_start;
        (startAccepted && !lockout) |=> (state_reg == CSS_TRICKLE || state_reg == CSS_BULK);
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_trickle_code;
        (state_reg == CSS_TRICKLE) |-> (!stateCodeHigh && !stateCodeLow);
    endproperty
    a_trickle_code: assert property (p_trickle_code) else $error("trickle code wrong");

    property p_trickle_exit;
        (state_reg == CSS_TRICKLE && senseSync_reg.trickleAbove && !lockout)
            |=> (state_reg == CSS_BULK && stateCodeLow && !stateCodeHigh);
    endproperty
    a_trickle_exit: assert property (p_trickle_exit) else $error("trickle did not leave");

    property p_bulk_code;
        (state_reg == CSS_BULK) |-> (stateCodeLow && !stateCodeHigh);
    endproperty
    a_bulk_code: assert property (p_bulk_code) else $error("bulk code wrong");

    property p_bulk_exit;
        (state_reg == CSS_BULK && senseSync_reg.feedbackAt95 && !lockout && !startAccepted)
            |=> (state_reg == CSS_OVER);
    endproperty
    a_bulk_exit: assert property (p_bulk_exit) else $error("bulk did not reach overcharge");

    property p_over_code;
        (state_reg == CSS_OVER) |-> (stateCodeHigh &&
            stateCodeLow == $past(senseSync_reg.nearFullAbove));
    endproperty
    a_over_code: assert property (p_over_code) else $error("overcharge code wrong");

    property p_timer_runs;
        (state_reg == CSS_OVER && oscTick && !timerClear && !(&timerCount))
            |=> (timerCount == $past(timerCount) + 1'b1);
    endproperty
    a_timer_runs: assert property (p_timer_runs) else $error("timer not counting");

    property p_near_keeps;
        (state_reg == CSS_OVER && senseSync_reg.nearFullAbove && !timerExpired
            && !lockout && !startAccepted) |=> (state_reg == CSS_OVER);
    endproperty
    a_near_keeps: assert property (p_near_keeps) else $error("near-full ended charging");

    property p_expiry_pull;
        (state_reg == CSS_OVER && timerExpired && !lockout && !startAccepted)
            |=> (chargeRequestOe && !chargeRequestOut)[*2];
    endproperty
    a_expiry_pull: assert property (p_expiry_pull) else $error("pin not pulled low");

    property p_clear;
        timerClear |=> (timerCount == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("timer not cleared");

    property p_idle_stays;
        (state_reg == CSS_IDLE && !startAccepted) |=> (state_reg == CSS_IDLE && $stable(timerCount));
    endproperty
    a_idle_stays: assert property (p_idle_stays) else $error("left idle without start");

    c_full_cycle: cover property (state_reg == CSS_OVER ##1 state_reg == CSS_PULL);
    c_near_full:  cover property (stateCodeHigh && stateCodeLow);
    c_skip:       cover property (state_reg == CSS_IDLE ##1 state_reg == CSS_BULK);
    c_irq:        cover property (irq);
endmodule
`default_nettype wire

/* core/css_consts.svh */
// constants of the charge-state sequencer: offsets, fields, reset values, timing
// assumes a 20 MHz ref_clk; included by bare name from css_top and css_timer, not from css_pkg
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH

`define CSS_CLK_MHZ          20
`define CSS_PULL_TIME_NS     1000
`define CSS_PULL_CYCLES      (((`CSS_PULL_TIME_NS * `CSS_CLK_MHZ) + 999) / 1000)
`define CSS_SETTLE_CYCLES    3
`define CSS_TIMER_W          14
`define CSS_HOLD_W           8

`define CSS_OFF_CTRL         8'h00
`define CSS_OFF_STATUS       8'h04
`define CSS_OFF_IRQ_STAT     8'h08
`define CSS_OFF_IRQ_MASK     8'h0c

`define CSS_CTRL_EN_BIT      0
`define CSS_CTRL_START_BIT   1
`define CSS_CTRL_RESET       1'h1

`define CSS_ST_CODE_LSB      0
`define CSS_ST_PIN_BIT       2
`define CSS_ST_BUSY_BIT      3
`define CSS_ST_TIMER_LSB     16

`define CSS_IRQ_W            5
`define CSS_IRQ_START        0
`define CSS_IRQ_BULK         1
`define CSS_IRQ_OVER         2
`define CSS_IRQ_NEAR         3
`define CSS_IRQ_DONE         4
`define CSS_IRQ_MASK_RESET   5'h00

`define CSS_CODE_TRICKLE     2'h0
`define CSS_CODE_BULK        2'h1
`define CSS_CODE_OVER        2'h2
`define CSS_CODE_NEAR        2'h3

`endif

/* core/css_pkg.sv */
// types of the charge-state sequencer
// assumes the constants header is compiled alongside
package css_pkg;
    typedef enum logic [2:0] {
        CSS_IDLE,
        CSS_TRICKLE,
        CSS_BULK,
        CSS_OVER,
        CSS_PULL,
        CSS_SETTLE
    } css_state_t;

    // digitized comparator results, all from the analog side
    typedef struct packed {
        logic supplyLockout;
        logic nearFullAbove;
        logic feedbackAt95;
        logic trickleAbove;
    } css_sense_t;
endpackage

/* core/css_timer.sv */
// overcharge timer: counter advanced by ticks of the timer oscillator
// assumes tick is a one-cycle pulse already in the ref_clk domain
`timescale 1ns/100ps
`default_nettype none
`include "css_consts.svh"

module css_timer #(
    parameter int WIDTH = `CSS_TIMER_W
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             clear,
    input  wire logic             run,
    input  wire logic             tick,
    output logic [WIDTH-1:0]      count,
    output logic                  expired
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic             expired_reg;
    wire              step    = run & tick & ~clear;
    wire              atFull  = &count_reg;

    // wrap to zero on expiry so a later cycle starts clean
    assign count_next = clear ? '0 : (step ? count_reg + 1'b1 : count_reg);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count_reg   <= '0;
            expired_reg <= 1'b0;
        end else begin
            count_reg   <= count_next;
            expired_reg <= step & atFull;
        end
    end

    assign count   = count_reg;
    assign expired = expired_reg;

    property p_full_range;
        @(posedge ref_clk) disable iff (srst)
        (step && atFull) |=> (expired && count_reg == '0);
    endproperty
    a_full_range: assert property (p_full_range) else $error("timer expiry not at full count");
endmodule
`default_nettype wire

/* tb/css_host_model.sv */
// host side of the charge-request pin: open-drain port with a pull-up on the line
// assumes the device only ever pulls the line low through its enable
`timescale 1ns/100ps
`default_nettype none

module css_host_model (
    input  wire logic ref_clk,
    input  wire logic deviceOe,
    input  wire logic deviceOut,
    output logic      pinLevel
);
    logic hostPullLow = 1'b1;

    // a released line reads high, so either party pulling low wins
    assign pinLevel = ((deviceOe && !deviceOut) || hostPullLow) ? 1'b0 : 1'b1;

    // hold low long enough for the device's synchroniser, then release
    task automatic startCycle();
        @(posedge ref_clk);
        hostPullLow <= 1'b1;
        repeat (4) @(posedge ref_clk);
        hostPullLow <= 1'b0;
    endtask

    // poll the pin as an input; low while released means the cycle ended
    task automatic waitEnd(input int limit, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < limit && !seen; i++) begin
            @(posedge ref_clk);
            #1;
            seen = (pinLevel === 1'b0);
        end
    endtask
endmodule

`default_nettype wire

/* tb/test_css_top.sv */
// self-checking bench for the charge-state sequencer: apb tasks and charge cycles
// assumes the host model on the request pin; the timer oscillator is made here
`timescale 1ns/100ps
`default_nettype none
`include "css_consts.svh"

module test_css_top;
    import css_pkg::*;
    localparam int TW    = 4;
    localparam int PULLC = 20;
    localparam int LIMIT = 20000;
    logic        ref_clk     = 1'b0;
    logic        srst        = 1'b1;
    logic [7:0]  paddr       = 8'h00;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [31:0] pwdata      = 32'h0;
    css_sense_t  sense       = 4'h0;
    logic        timerOsc    = 1'b0;
    logic        oscRun      = 1'b0;
    int          oscEdges    = 0;
    int          miscompares = 0;
    int          checks      = 0;
    int          cycles      = 0;
    int          n;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        pinLevel;
    logic        chargeRequestOut;
    logic        chargeRequestOe;
    logic        stateCodeLow;
    logic        stateCodeHigh;
    logic [31:0] rdv;
    logic        errv;
    logic        seen;

    // short timer so a full overcharge fits the run
    css_top #(.TIMER_W(TW), .PULL_CYCLES(PULLC)) dut_u (
        .ref_clk          (ref_clk),
        .srst             (srst),
        .paddr            (paddr),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .irq              (irq),
        .chargeRequestIn  (pinLevel),
        .chargeRequestOut (chargeRequestOut),
        .chargeRequestOe  (chargeRequestOe),
        .senseIn          (sense),
        .timerOscIn       (timerOsc),
        .stateCodeLow     (stateCodeLow),
        .stateCodeHigh    (stateCodeHigh)
    );

    css_host_model host_u (
        .ref_clk  (ref_clk),
        .deviceOe (chargeRequestOe),
        .deviceOut(chargeRequestOut),
        .pinLevel (pinLevel)
    );

    always #25 ref_clk = ~ref_clk;

    // oscillator eight clocks per period, far slower than the synchroniser
    always begin
        repeat (4) @(posedge ref_clk);
        if (oscRun) begin
            timerOsc <= ~timerOsc;
            oscEdges <= oscEdges + (timerOsc ? 0 : 1);
        end
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmpWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // the #1 lets registered outputs of the edge settle first
    task automatic cmpFlag(input string what, input logic exp, input logic got);
        #1;
        cmpWord(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic apb(input logic isWrite, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= isWrite;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) miscompares++;
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // the write lands at the access edge; wait past it so outputs show its effect
    task automatic writeReg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdv, errv);
        #1;
    endtask

    task automatic checkReg(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rdv, errv);
        cmpWord(what, exp, rdv);
    endtask

    task automatic readStatus();
        apb(1'b0, `CSS_OFF_STATUS, 32'h0, rdv, errv);
    endtask

    task automatic setSense(input css_sense_t s);
        @(posedge ref_clk);
        sense <= s;
    endtask

    task automatic expectCode(input logic [1:0] exp, input string what);
        for (int i = 0; i < 40 && {stateCodeHigh, stateCodeLow} !== exp; i++) begin
            @(posedge ref_clk);
            #1;
        end
        cmpWord(what, {30'h0, exp}, {30'h0, stateCodeHigh, stateCodeLow});
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        checkReg("ctrl reset", `CSS_OFF_CTRL, 32'h1);
        checkReg("status reset", `CSS_OFF_STATUS, 32'h0);
        checkReg("mask reset", `CSS_OFF_IRQ_MASK, 32'h0);
        apb(1'b0, 8'h10, 32'h0, rdv, errv);
        cmpFlag("unmapped error", 1'b1, errv);
        cmpWord("unmapped data", 32'h0, rdv);
        // starts by pin or by software are refused while disabled
        writeReg(`CSS_OFF_CTRL, 32'h2);
        checkReg("ctrl disabled", `CSS_OFF_CTRL, 32'h0);
        host_u.startCycle();
        repeat (6) @(posedge ref_clk);
        readStatus();
        cmpWord("start while disabled", 32'h4, rdv);
        writeReg(`CSS_OFF_CTRL, 32'h1);
        // deep-discharged battery through a whole cycle
        host_u.startCycle();
        repeat (10) @(posedge ref_clk);
        readStatus();
        cmpWord("trickle status", 32'hc, rdv);
        setSense(4'b0001);
        expectCode(`CSS_CODE_BULK, "bulk code");
        setSense(4'b0011);
        expectCode(`CSS_CODE_OVER, "overcharge code");
        readStatus();
        cmpWord("timer before ticks", 32'h0, {18'h0, rdv[29:16]});
        oscRun <= 1'b1;
        wait (oscEdges == 4);
        repeat (3) @(posedge ref_clk);
        readStatus();
        cmpWord("timer running", 32'h4, {18'h0, rdv[29:16]});
        setSense(4'b0111);
        expectCode(`CSS_CODE_NEAR, "near-full code");
        cmpFlag("still charging", 1'b0, chargeRequestOe);
        host_u.waitEnd(400, seen);
        cmpFlag("pin pulled low", 1'b1, seen);
        cmpWord("ticks to expiry", 32'(1 << TW), 32'(oscEdges));
        n = 0;
        while (chargeRequestOe === 1'b1 && n < 100) begin
            n++;
            @(posedge ref_clk);
            #1;
        end
        cmpWord("pull length", 32'(PULLC), 32'(n));
        // pin rises again on release; that must not restart
        expectCode(`CSS_CODE_TRICKLE, "idle code");
        repeat (30) @(posedge ref_clk);
        readStatus();
        cmpWord("idle status", 32'h4, rdv & 32'h0000_000f);
        checkReg("irq status", `CSS_OFF_IRQ_STAT, 32'h1f);
        cmpFlag("irq masked", 1'b0, irq);
        writeReg(`CSS_OFF_IRQ_MASK, 32'h10);
        cmpFlag("irq raised", 1'b1, irq);
        writeReg(`CSS_OFF_IRQ_STAT, 32'h1f);
        cmpFlag("irq cleared", 1'b0, irq);
        checkReg("irq status cleared", `CSS_OFF_IRQ_STAT, 32'h0);
        // charged battery skips trickle; restart and lockout clear the timer
        oscRun <= 1'b0;
        setSense(4'b0001);
        host_u.startCycle();
        repeat (10) @(posedge ref_clk);
        readStatus();
        cmpWord("skip trickle status", 32'hd, rdv & 32'h0000_000f);
        setSense(4'b0011);
        expectCode(`CSS_CODE_OVER, "second overcharge");
        oscRun <= 1'b1;
        repeat (40) @(posedge ref_clk);
        oscRun <= 1'b0;
        repeat (8) @(posedge ref_clk);
        readStatus();
        cmpFlag("timer advanced", 1'b1, |rdv[29:16]);
        writeReg(`CSS_OFF_CTRL, 32'h3);
        repeat (6) @(posedge ref_clk);
        readStatus();
        cmpWord("timer after restart", 32'h0, {18'h0, rdv[29:16]});
        oscRun <= 1'b1;
        repeat (40) @(posedge ref_clk);
        setSense(4'b1011);
        expectCode(`CSS_CODE_TRICKLE, "lockout code");
        readStatus();
        cmpWord("lockout status", 32'h4, rdv);
        conclude();
    end
endmodule

`default_nettype wire
